// ==== verification/pirq_core_model.sv ====
// Core model that takes presented requests after a set delay
`timescale 1ns/1ns
module pirq_core_model (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic                      irqReq,
    input  wire logic [pirq_pkg::VEC_W-1:0] irqVec,
    input  wire logic                      ackEn,
    input  wire logic [3:0]                ackDly,
    output logic                           irqAck,
    output logic      [pirq_pkg::VEC_W-1:0] takenVec,
    output logic      [7:0]                takenCnt
);
    import pirq_pkg::*;
    logic [3:0] waitCnt_ff;
    // Ack only a request still shown after the wait
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irqAck     <= 1'b0;
            takenVec   <= '0;
            takenCnt   <= '0;
            waitCnt_ff <= '0;
        end else begin
            irqAck <= 1'b0;
            if (!irqReq || !ackEn || irqAck) begin
                waitCnt_ff <= '0;
            end else if (waitCnt_ff < ackDly) begin
                waitCnt_ff <= waitCnt_ff + 4'h1;
            end else begin
                irqAck   <= 1'b1;
                takenVec <= irqVec;
                takenCnt <= takenCnt + 8'h01;
            end
        end
    end
endmodule : pirq_core_model

// ==== verification/tb_top.sv ====
// Self-checking bench of the priority interrupt unit
`timescale 1ns/1ns
module tb_top;
    import pirq_pkg::*;
    logic               clk_sys, rst_n, swSetEn, swClrEn, prioWrEn, maskWrEn;
    logic               irqAck, eoi, nmiReq, irqReq, critReq, ackEn;
    logic [NUM_SRC-1:0] hwReq;
    logic [2:0]         swSetIdx, swClrIdx;
    logic [SRC_W-1:0]   prioWrSrc, prioRdSrc;
    logic [PRIO_W-1:0]  prioWrVal, maskWrVal, prioRdVal, curMask;
    logic [PRIO_W-1:0]  irqPrio, ackDly;
    logic [VEC_W-1:0]   irqVec, takenVec;
    logic [NUM_SW-1:0]  swPend, swExp;
    logic [7:0]         takenCnt;
    int                 errCount = 0;
    int                 checks = 0;
    pirq_ctrl u_pirq_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .hwReq(hwReq),
        .swSetEn(swSetEn), .swSetIdx(swSetIdx), .swClrEn(swClrEn),
        .swClrIdx(swClrIdx), .prioWrEn(prioWrEn), .prioWrSrc(prioWrSrc),
        .prioWrVal(prioWrVal), .prioRdSrc(prioRdSrc), .maskWrEn(maskWrEn),
        .maskWrVal(maskWrVal), .irqAck(irqAck), .eoi(eoi), .nmiReq(nmiReq),
        .prioRdVal(prioRdVal), .curMask(curMask), .irqReq(irqReq),
        .irqVec(irqVec), .irqPrio(irqPrio), .swPend(swPend), .critReq(critReq));
    pirq_core_model u_pirq_core_model (.clk_sys(clk_sys), .rst_n(rst_n),
        .irqReq(irqReq), .irqVec(irqVec), .ackEn(ackEn), .ackDly(ackDly),
        .irqAck(irqAck), .takenVec(takenVec), .takenCnt(takenCnt));
    // Clock source
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic finish_test;
        $display("checks %0d errors %0d", checks, errCount);
        if (errCount == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [8:0] ex,
                       input logic [8:0] got);
        checks++;
        if (got !== ex) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : idle
    task automatic setPrio(input logic [SRC_W-1:0] s,
                           input logic [PRIO_W-1:0] v);
        {prioWrEn, prioWrSrc, prioWrVal} = {1'b1, s, v};
        idle(1);
        prioWrEn = 1'b0;
        idle(1);
    endtask : setPrio
    task automatic setMask(input logic [PRIO_W-1:0] v);
        {maskWrEn, maskWrVal} = {1'b1, v};
        idle(1);
        maskWrEn = 1'b0;
        idle(1);
    endtask : setMask
    task automatic endService;
        eoi = 1'b1;
        idle(1);
        eoi = 1'b0;
        idle(1);
    endtask : endService
    task automatic waitVec(input logic [SRC_W-1:0] s);
        for (int i = 0; i < 12 && !(irqReq === 1'b1 &&
             irqVec === VEC_BASE + VEC_W'(s)); i++) idle(1);
        chk("irqVec", VEC_BASE + VEC_W'(s), irqVec);
        chk("irqReq", 9'h001, {8'h00, irqReq});
        if (irqReq !== 1'b1) finish_test();
    endtask : waitVec
    task automatic waitAck(input logic [7:0] n);
        for (int i = 0; i < 20 && takenCnt !== n; i++) idle(1);
        chk("takenCnt", {1'b0, n}, {1'b0, takenCnt});
        if (takenCnt !== n) finish_test();
    endtask : waitAck
    // Main sequence
    initial begin
        {rst_n, swSetEn, swClrEn, prioWrEn, maskWrEn, eoi, nmiReq, ackEn} = '0;
        {hwReq, swSetIdx, swClrIdx, prioWrSrc, prioRdSrc, prioWrVal} = '0;
        {maskWrVal, ackDly, swExp} = '0;
        idle(3);
        rst_n = 1'b1;
        chk("curMask", {5'h00, MASK_RST}, {5'h00, curMask});
        setPrio(7'h05, 4'h3);
        prioRdSrc = 7'h05;
        idle(1);
        chk("prioRdVal", 9'h003, {5'h00, prioRdVal});
        hwReq[9] = 1'b1;
        idle(3);
        chk("irqReq", 9'h000, {8'h00, irqReq});
        setPrio(7'h09, 4'h1);
        waitVec(7'h09);
        setPrio(7'h28, 4'h6);
        setPrio(7'h14, 4'h6);
        setPrio(7'h7F, 4'h2);
        hwReq[127] = 1'b1;
        hwReq[40] = 1'b1;
        hwReq[20] = 1'b1;
        waitVec(7'h14);
        idle(4);
        chk("irqVec", 9'h014, irqVec);
        chk("irqPrio", 9'h006, {5'h00, irqPrio});
        setMask(4'h6);
        idle(2);
        chk("irqReq", 9'h000, {8'h00, irqReq});
        setPrio(7'h7F, 4'h7);
        waitVec(7'h7F);
        setMask(4'h0);
        hwReq = '0;
        hwReq[5] = 1'b1;
        waitVec(7'h05);
        ackEn = 1'b1;
        waitAck(8'h01);
        hwReq[5] = 1'b0;
        idle(1);
        chk("curMask", 9'h003, {5'h00, curMask});
        ackDly = 4'h3;
        hwReq[40] = 1'b1;
        waitAck(8'h02);
        chk("takenVec", 9'h028, takenVec);
        {hwReq[40], hwReq[20]} = 2'b01;
        idle(6);
        chk("takenCnt", 9'h002, {1'b0, takenCnt});
        endService();
        waitAck(8'h03);
        hwReq[20] = 1'b0;
        idle(1);
        chk("curMask", 9'h006, {5'h00, curMask});
        endService();
        endService();
        chk("curMask", 9'h000, {5'h00, curMask});
        ackEn = 1'b0;
        swSetEn = 1'b1;
        for (int i = 0; i < 8; i++) begin
            swSetIdx = 3'(i);
            idle(1);
            swExp[i] = 1'b1;
            chk("swPend", {1'b0, swExp}, {1'b0, swPend});
        end
        swSetEn = 1'b0;
        setPrio(7'h03, 4'h9);
        waitVec(7'h03);
        swClrEn = 1'b1;
        for (int i = 0; i < 8; i++) begin
            swClrIdx = 3'(i);
            idle(1);
        end
        swClrEn = 1'b0;
        idle(2);
        chk("swPend", 9'h000, {1'b0, swPend});
        setMask(4'hF);
        nmiReq = 1'b1;
        idle(2);
        chk("critReq", 9'h001, {8'h00, critReq});
        nmiReq = 1'b0;
        idle(2);
        chk("critReq", 9'h000, {8'h00, critReq});
        finish_test();
    end
endmodule : tb_top

// ==== verilog/pirq_ctrl.sv ====
// Priority preemptive interrupt controller top
`timescale 1ns/1ns
module pirq_ctrl
    import pirq_pkg::*;
#(
    parameter int NSRC = NUM_SRC
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic [NSRC-1:0]      hwReq,
    input  wire logic                 swSetEn,
    input  wire logic [2:0]           swSetIdx,
    input  wire logic                 swClrEn,
    input  wire logic [2:0]           swClrIdx,
    input  wire logic                 prioWrEn,
    input  wire logic [SRC_W-1:0]     prioWrSrc,
    input  wire logic [PRIO_W-1:0]    prioWrVal,
    input  wire logic [SRC_W-1:0]     prioRdSrc,
    input  wire logic                 maskWrEn,
    input  wire logic [PRIO_W-1:0]    maskWrVal,
    input  wire logic                 irqAck,
    input  wire logic                 eoi,
    input  wire logic                 nmiReq,
    output logic      [PRIO_W-1:0]    prioRdVal,
    output logic      [PRIO_W-1:0]    curMask,
    output logic                      irqReq,
    output logic      [VEC_W-1:0]     irqVec,
    output logic      [PRIO_W-1:0]    irqPrio,
    output logic      [NUM_SW-1:0]    swPend,
    output logic                      critReq
);
    import pirq_pkg::*;

    // Refuse any source count other than NUM_SRC (128), even one the index and vector widths could carry
    if (NSRC != NUM_SRC) begin : g_bad_nsrc
        $error("pirq_ctrl: NSRC must be 128");
    end

    logic [NSRC*PRIO_W-1:0] allPrio;
    logic [NUM_SW-1:0]      swPend_ff;
    logic [PRIO_W-1:0]      mask_ff;
    logic [PRIO_W-1:0]      stackFf [STACK_DEPTH];
    logic [4:0]             sp_ff;
    logic                   req_ff;
    logic [SRC_W-1:0]       src_ff;
    logic [PRIO_W-1:0]      pri_ff;
    logic [VEC_W-1:0]       vec_ff;
    logic                   crit_ff;
    logic [NSRC-1:0]        pend;
    logic                   winVld;
    logic [SRC_W-1:0]       winSrc;
    logic [PRIO_W-1:0]      winPri;
    logic                   curStill;

    // Source vector from source number
    function automatic logic [VEC_W-1:0] vecOf(input logic [SRC_W-1:0] s);
        vecOf = VEC_BASE + {2'h0, s};
    endfunction : vecOf

    pirq_prio_mem #(.DEPTH(NSRC)) uMem (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wrEn    (prioWrEn),
        .wrAddr  (prioWrSrc),
        .wrData  (prioWrVal),
        .rdAddr  (prioRdSrc),
        .rdData  (prioRdVal),
        .allPrio (allPrio)
    );

    // Software-triggered sources; set wins over clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            swPend_ff <= '0;
        end else begin
            for (int i = 0; i < NUM_SW; i++) begin
                if (swSetEn && swSetIdx == i[2:0])
                    swPend_ff[i] <= 1'b1;
                else if (swClrEn && swClrIdx == i[2:0])
                    swPend_ff[i] <= 1'b0;
            end
        end
    end

    // Low sources are the software ones
    always_comb begin
        pend = hwReq;
        pend[NUM_SW-1:0] = hwReq[NUM_SW-1:0] | swPend_ff;
    end

    // Highest priority wins, lowest number on ties
    always_comb begin
        winVld = 1'b0;
        winSrc = '0;
        winPri = '0;
        for (int i = NSRC-1; i >= 0; i--) begin
            if (pend[i] && allPrio[i*PRIO_W +: PRIO_W] != 4'h0 &&
                (!winVld || allPrio[i*PRIO_W +: PRIO_W] >= winPri)) begin
                winVld = 1'b1;
                winSrc = i[SRC_W-1:0];
                winPri = allPrio[i*PRIO_W +: PRIO_W];
            end
        end
    end

    // Current mask: software write, push on ack, pop on end of service
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= MASK_RST;
            sp_ff   <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) stackFf[i] <= MASK_RST;
        end else if (req_ff && irqAck && sp_ff != 5'(STACK_DEPTH)) begin
            stackFf[sp_ff[3:0]] <= mask_ff;
            sp_ff   <= sp_ff + 5'h1;
            mask_ff <= pri_ff;
        end else if (eoi && sp_ff != 5'h0) begin
            mask_ff <= stackFf[sp_ff[3:0] - 4'h1];
            sp_ff   <= sp_ff - 5'h1;
        end else if (maskWrEn) begin
            mask_ff <= maskWrVal;
        end
    end

    // Presented source still pending at its captured level
    always_comb begin
        curStill = pend[src_ff] &&
                   allPrio[src_ff*PRIO_W +: PRIO_W] == pri_ff;
    end

    // Presented request; a gone source is withdrawn, not swapped in place
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            req_ff <= 1'b0;
            src_ff <= '0;
            pri_ff <= '0;
            vec_ff <= VEC_BASE;
        end else if (req_ff && irqAck) begin
            req_ff <= 1'b0;
        end else if (!req_ff || winPri > pri_ff) begin
            req_ff <= winVld && winPri > mask_ff;
            src_ff <= winSrc;
            pri_ff <= winPri;
            vec_ff <= vecOf(winSrc);
        end else if (!curStill || pri_ff <= mask_ff) begin
            req_ff <= 1'b0;
        end
    end

    // Non-maskable path straight to the critical input
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) crit_ff <= 1'b0;
        else        crit_ff <= nmiReq;
    end

    // Outputs from flip-flops
    always_comb begin
        irqReq  = req_ff;
        irqVec  = vec_ff;
        irqPrio = pri_ff;
        curMask = mask_ff;
        swPend  = swPend_ff;
        critReq = crit_ff;
    end

    // Gating of the presented request, the critical path, vector stability and software set
    a_mask_gate: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        irqReq |-> irqPrio > $past(curMask))
        else $error("request presented at or below mask");
    a_nmi_pass: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        nmiReq |=> critReq)
        else $error("critical request not forwarded");
    a_vec_stable: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        irqReq && !irqAck |=>
        !irqReq || irqPrio > $past(irqPrio) || $stable(irqVec))
        else $error("vector changed while presented");
    a_sw_set: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        swSetEn |=> swPend[$past(swSetIdx)])
        else $error("software source not set");

    // Mask stack behaviour
    a_mask_write: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        maskWrEn && !eoi && !(irqReq && irqAck) |=>
        curMask == $past(maskWrVal))
        else $error("mask write lost");
    a_ack_raise: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        irqReq && irqAck && sp_ff != 5'h10 |=> curMask == $past(irqPrio))
        else $error("mask not raised on ack");
    a_eoi_pop: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        eoi && sp_ff != 5'h0 && !(irqReq && irqAck) |=>
        sp_ff == $past(sp_ff) - 5'h1)
        else $error("stack not popped on end of service");

    // Priority storage, vector range and level checks
    a_prio_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        prioWrEn ##1 (prioRdSrc == $past(prioWrSrc)) |=>
        prioRdVal == $past(prioWrVal, 2))
        else $error("priority not stored");
    a_vec_range: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        irqReq |-> irqVec - VEC_BASE < 9'(NSRC))
        else $error("vector outside source range");
    a_no_zero: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        irqReq |-> irqPrio != 4'h0)
        else $error("level zero presented");

    // Taken or gone requests are not left standing
    a_ack_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        irqReq && irqAck |=> !irqReq)
        else $error("request still shown after ack");
    a_src_live: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        irqReq && !irqAck && !curStill && winPri <= irqPrio |=> !irqReq)
        else $error("request kept for a source no longer pending");

    // Main scenarios
    c_irq: cover property (@(posedge clk_sys) irqReq && irqAck);
    c_withdraw: cover property (@(posedge clk_sys) irqReq && !curStill);
    c_preempt: cover property (@(posedge clk_sys)
        irqReq && irqAck ##[1:20] irqReq && irqPrio > curMask);
    c_nmi: cover property (@(posedge clk_sys) critReq);
    c_eoi: cover property (@(posedge clk_sys) eoi && sp_ff != 5'h0);
endmodule : pirq_ctrl

// ==== verilog/pirq_pkg.sv ====
// Constants of the priority interrupt unit
// Contract
// - Accept 128 independent sources, each with its own priority.
// - Each source has its own distinct 9-bit vector.
// - Eight sources are raised by software writes.
// - Sixteen levels; fixed hardware arbitration among equal levels.
// - Per-source priority held in software-writable configuration.
// - Higher-priority pending request preempts the routine in service.
// - Software-modifiable current priority mask for ceiling-style sharing.
// - External non-maskable request bypasses scheduling to critical input.
package pirq_pkg;
    localparam int NUM_SRC      = 128;
    localparam int SRC_W        = 7;
    localparam int PRIO_W       = 4;
    localparam int VEC_W        = 9;
    localparam int NUM_SW       = 8;
    localparam int STACK_DEPTH  = 16;
    localparam logic [PRIO_W-1:0] PRIO_RST = 4'h0;
    localparam logic [PRIO_W-1:0] MASK_RST = 4'h0;
    localparam logic [VEC_W-1:0]  VEC_BASE = 9'h000;
endpackage : pirq_pkg

// ==== verilog/pirq_prio_mem.sv ====
// Per-source priority memory with registered read port
`timescale 1ns/1ns
module pirq_prio_mem
    import pirq_pkg::*;
#(
    parameter int DEPTH = NUM_SRC
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  wrEn,
    input  wire logic [SRC_W-1:0]      wrAddr,
    input  wire logic [PRIO_W-1:0]     wrData,
    input  wire logic [SRC_W-1:0]      rdAddr,
    output logic      [PRIO_W-1:0]     rdData,
    output logic      [DEPTH*PRIO_W-1:0] allPrio
);
    logic [PRIO_W-1:0] memFf [DEPTH];

    // Refuse a depth the address width cannot reach
    if (DEPTH < 1 || DEPTH > 2**SRC_W) begin : g_bad_depth
        $error("pirq_prio_mem: DEPTH out of range");
    end

    // Software-written priority per source
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) memFf[i] <= PRIO_RST;
        end else if (wrEn) begin
            memFf[wrAddr] <= wrData;
        end
    end

    // Registered readback
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) rdData <= PRIO_RST;
        else        rdData <= memFf[rdAddr];
    end

    // Flat view for the arbiter
    always_comb begin
        for (int i = 0; i < DEPTH; i++)
            allPrio[i*PRIO_W +: PRIO_W] = memFf[i];
    end
endmodule : pirq_prio_mem
